// file: log_sense_pkg.sv
// Shared constants and types for the log sense target and its initiator.
// Assumes one 100 MHz clock pclk and an active-low asynchronous presetn.
package log_sense_pkg;
  localparam logic [7:0]  OPC_LOG_SENSE  = 8'h4D;
  localparam logic [1:0]  CTL_CUR_CUMUL  = 2'b01;
  localparam logic [7:0]  STAT_GOOD      = 8'h00;
  localparam logic [7:0]  STAT_CHECK     = 8'h02;
  localparam logic [3:0]  SK_NONE        = 4'h0;
  localparam logic [3:0]  SK_ILLEGAL     = 4'h5;
  localparam logic [7:0]  ASC_NONE       = 8'h00;
  localparam logic [7:0]  ASC_INV_OPC    = 8'h20;
  localparam logic [7:0]  ASC_INV_CDB    = 8'h24;
  // Format and linking codes
  localparam logic [1:0]  FL_CNT_STOP    = 2'b00;
  localparam logic [1:0]  FL_LIST_ASCII  = 2'b01;
  localparam logic [1:0]  FL_CNT_RUN     = 2'b10;
  localparam logic [1:0]  FL_LIST_BIN    = 2'b11;
  // Supported pages, entry 0 last
  localparam int          N_PAGES        = 15;
  localparam logic [N_PAGES-1:0][7:0] PAGE_LIST = {
    8'h38, 8'h30, 8'h2F, 8'h1A, 8'h15, 8'h11, 8'h10, 8'h0F,
    8'h0E, 8'h0D, 8'h06, 8'h05, 8'h03, 8'h02, 8'h00};
  localparam logic [15:0] PG0_LEN        = 16'h000F;
  localparam logic [15:0] PAGE_HDR_BYTES = 16'h0004;
  localparam logic [15:0] PARM_HDR_BYTES = 16'h0004;
  localparam logic [7:0]  PARM_VAL_LEN   = 8'h04;
  localparam logic [15:0] CNT_PAGE_LEN   = 16'h0010;
  // CDB field positions
  localparam int          CDB_BYTES      = 10;
  localparam int          B_OPC          = 0;
  localparam int          B_FLAGS        = 1;
  localparam int          B_PAGE         = 2;
  localparam int          B_SUBPAGE      = 3;
  localparam int          B_PTR_HI       = 5;
  localparam int          B_PTR_LO       = 6;
  localparam int          B_ALLOC_HI     = 7;
  localparam int          B_ALLOC_LO     = 8;
  localparam int          BIT_PTR_CTL    = 1;
  localparam int          BIT_SAVE       = 0;
  typedef logic [CDB_BYTES-1:0][7:0] cdb_t;
  // Initiator APB map
  localparam logic [7:0]  OFS_CDB0       = 8'h00;
  localparam logic [7:0]  OFS_CDB1       = 8'h04;
  localparam logic [7:0]  OFS_CDB2       = 8'h08;
  localparam logic [7:0]  OFS_CTRL       = 8'h0C;
  localparam logic [7:0]  OFS_STAT       = 8'h10;
  localparam logic [7:0]  OFS_SENSE      = 8'h14;
  localparam logic [7:0]  OFS_COUNT      = 8'h18;
  localparam logic [2:0]  BUF_WIN        = 3'h1;
  localparam int          BUF_WORDS      = 8;
  localparam logic [15:0] BUF_BYTES      = 16'h0020;
endpackage

// file: log_link_if.sv
// Link between the log sense target and the initiator end.
// Assumes both ends share pclk and presetn.
`timescale 1ns/1ps
interface log_link_if (
  input wire logic pclk,
  input wire logic presetn
);
  import log_sense_pkg::*;
  logic       cdb_valid;
  cdb_t       cdb;
  logic       dev_busy;
  logic       din_valid;
  logic [7:0] din;
  logic       stat_valid;
  logic [7:0] status;
  logic [3:0] sense_key;
  logic [7:0] asc;
  modport dev (input cdb_valid, cdb, output dev_busy, din_valid, din, stat_valid, status,
               sense_key, asc);
  modport ini (output cdb_valid, cdb, input dev_busy, din_valid, din, stat_valid, status,
               sense_key, asc);
endinterface

// file: log_sense_target.sv
// Log sense command target: checks the CDB, streams log pages, reports status.
// Assumes the initiator accepts one data byte per cycle and waits for status.
// What this block does
// - Opcode 4Dh selects the log sense command
// - Pointer-control bit set gives invalid field check
// - Save bit set on a good command pulses save_stb
// - Page control other than 01b is rejected
// - Unsupported page code is rejected
// - Initiator keeps subpage code at zero
// - Non-zero parameter pointer is rejected
// - Zero allocation length: no data, good status
// - Send smaller of page size and allocation
// - Page header: code and parameter byte count
// - Parameter header with control byte, then data
// - Disable-update flag zero, counters keep updating
// - Target-save-disable flag reported as zero
// - Threshold enable and criteria reported as zero
// - Code 00b counter stops when neighbour saturates
// - Code 10b counter keeps counting past neighbour
// - Codes 01b and 11b mark lists, no saturation
// - Page zero code 0, length 000Fh
// - Page zero lists fifteen codes ascending
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
module log_sense_target
  import log_sense_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  log_link_if.dev          link,
  input  wire logic        evt_stb,
  input  wire logic [3:0]  evt_page,
  input  wire logic        evt_param,
  input  wire logic        log_reinit,
  output logic             save_stb
);
  import log_sense_pkg::*;

  localparam int N_CNT = N_PAGES - 1;

  typedef enum logic [1:0] {S_IDLE, S_SEND, S_STAT} st_t;

  typedef struct packed {
    st_t                          st;
    logic [7:0]                   pg;
    logic [3:0]                   idx;
    logic [15:0]                  pos;
    logic [15:0]                  lim;
    logic                         busy;
    logic                         dv;
    logic [7:0]                   d;
    logic                         sv;
    logic [7:0]                   status;
    logic [3:0]                   sk;
    logic [7:0]                   asc;
    logic                         save;
    logic [N_CNT-1:0][1:0][31:0]  cnt;
  } state_t;

  state_t            s_q;
  state_t            s_d;
  logic [N_PAGES-1:0] hit;
  cdb_t              c;

  assign c = link.cdb;

  genvar gi;
  generate
    for (gi = 0; gi < N_PAGES; gi++) begin : g_hit
      assign hit[gi] = (c[B_PAGE][5:0] == PAGE_LIST[gi][5:0]);
    end
  endgenerate

  // One byte of the selected page at offset pos
  function automatic logic [7:0] page_byte(
    input logic [3:0]                  idx,
    input logic [7:0]                  pg,
    input logic [15:0]                 pos,
    input logic [N_CNT-1:0][1:0][31:0] cnt
  );
    logic [15:0] len;
    logic [15:0] off;
    logic        p;
    logic [31:0] v;
    logic [7:0]  b;
    len = (idx == 4'd0) ? PG0_LEN : CNT_PAGE_LEN;
    off = pos - PAGE_HDR_BYTES;
    p   = off[3];
    v   = (idx == 4'd0) ? 32'h0000_0000 : cnt[idx - 4'd1][p];
    b   = 8'h00;
    if (pos == 16'h0000) begin
      b = {2'b00, pg[5:0]};
    end else if (pos == 16'h0002) begin
      b = len[15:8];
    end else if (pos == 16'h0003) begin
      b = len[7:0];
    end else if (pos >= PAGE_HDR_BYTES) begin
      if (idx == 4'd0) begin
        b = PAGE_LIST[off[3:0]];
      end else begin
        case (off[2:0])
          3'd1:    b = {7'b000_0000, p};
          // Control byte: update, save, target save, threshold bits all zero
          // Only counters live here, so the list codes are never emitted
          3'd2:    b = {6'b00_0000, p ? FL_CNT_RUN : FL_CNT_STOP};
          3'd3:    b = PARM_VAL_LEN;
          3'd4:    b = v[31:24];
          3'd5:    b = v[23:16];
          3'd6:    b = v[15:8];
          3'd7:    b = v[7:0];
          default: b = 8'h00;
        endcase
      end
    end
    return b;
  endfunction

  always_comb begin
    logic [15:0] alloc;
    logic [15:0] total;
    logic [3:0]  idx;
    logic        bad;
    alloc = {c[B_ALLOC_HI], c[B_ALLOC_LO]};
    total = 16'h0000;
    idx   = 4'd0;
    bad   = 1'b0;
    s_d   = s_q;
    s_d.save = 1'b0;
    s_d.sv   = 1'b0;
    s_d.dv   = 1'b0;

    // Counters update while idle or busy
    for (int k = 0; k < N_CNT; k++) begin
      if (log_reinit) begin
        s_d.cnt[k] = '0;
      end else if (evt_stb && (evt_page == 4'(k + 1))) begin
        if (!evt_param) begin
          // Frozen once either parameter of the page hits its maximum
          if (!(&s_q.cnt[k][0]) && !(&s_q.cnt[k][1])) begin
            s_d.cnt[k][0] = s_q.cnt[k][0] + 32'h0000_0001;
          end
        end else if (!(&s_q.cnt[k][1])) begin
          s_d.cnt[k][1] = s_q.cnt[k][1] + 32'h0000_0001;
        end
      end
    end

    case (s_q.st)
      S_IDLE: begin
        if (link.cdb_valid && !s_q.busy) begin
          for (int i = 0; i < N_PAGES; i++) begin
            if (hit[i]) begin
              idx = 4'(i);
            end
          end
          // Subpage is not checked; the initiator keeps it zero
          bad = c[B_FLAGS][BIT_PTR_CTL]
              || (c[B_PAGE][7:6] != CTL_CUR_CUMUL)
              || !(|hit)
              || ({c[B_PTR_HI], c[B_PTR_LO]} != 16'h0000);
          total = PAGE_HDR_BYTES + ((idx == 4'd0) ? PG0_LEN : CNT_PAGE_LEN);
          s_d.busy = 1'b1;
          s_d.pg   = c[B_PAGE];
          s_d.idx  = idx;
          s_d.pos  = 16'h0000;
          s_d.lim  = (alloc < total) ? alloc : total;
          s_d.st   = S_STAT;
          if (c[B_OPC] != OPC_LOG_SENSE) begin
            s_d.status = STAT_CHECK;
            s_d.sk     = SK_ILLEGAL;
            s_d.asc    = ASC_INV_OPC;
          end else if (bad) begin
            s_d.status = STAT_CHECK;
            s_d.sk     = SK_ILLEGAL;
            s_d.asc    = ASC_INV_CDB;
          end else begin
            s_d.status = STAT_GOOD;
            s_d.sk     = SK_NONE;
            s_d.asc    = ASC_NONE;
            s_d.save   = c[B_FLAGS][BIT_SAVE];
            if (alloc != 16'h0000) begin
              s_d.st = S_SEND;
            end
          end
        end
      end
      S_SEND: begin
        s_d.dv  = 1'b1;
        s_d.d   = page_byte(s_q.idx, s_q.pg, s_q.pos, s_q.cnt);
        s_d.pos = s_q.pos + 16'h0001;
        if (s_q.pos + 16'h0001 == s_q.lim) begin
          s_d.st = S_STAT;
        end
      end
      S_STAT: begin
        s_d.sv   = 1'b1;
        s_d.busy = 1'b0;
        s_d.st   = S_IDLE;
      end
      default: s_d.st = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign link.dev_busy   = s_q.busy;
  assign link.din_valid  = s_q.dv;
  assign link.din        = s_q.d;
  assign link.stat_valid = s_q.sv;
  assign link.status     = s_q.status;
  assign link.sense_key  = s_q.sk;
  assign link.asc        = s_q.asc;
  assign save_stb        = s_q.save;
endmodule

// file: log_sense_initiator.sv
// Initiator end: software loads a CDB over APB, starts it, reads status and data.
// Assumes APB master on pclk; the target answers every CDB with one status.
`timescale 1ns/1ps
module log_sense_initiator
  import log_sense_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  log_link_if.ini          link
);
  import log_sense_pkg::*;

  typedef struct packed {
    cdb_t                         cdb;
    logic                         strict;
    logic                         busy;
    logic                         done;
    logic                         rej;
    logic                         cv;
    logic [7:0]                   status;
    logic [3:0]                   sk;
    logic [7:0]                   asc;
    logic [15:0]                  cnt;
    logic [BUF_WORDS*4-1:0][7:0]  buff;
    logic                         rdy;
    logic                         err;
    logic [31:0]                  rd;
  } state_t;

  state_t s_q;
  state_t s_d;

  always_comb begin
    logic ok;
    logic wr;
    ok   = 1'b0;
    wr   = psel && penable && s_q.rdy && pwrite;
    for (int i = 0; i < N_PAGES; i++) begin
      if (s_q.cdb[B_PAGE][5:0] == PAGE_LIST[i][5:0]) begin
        ok = 1'b1;
      end
    end
    // Legal CDB fields as the initiator must send them; the opcode is not checked
    ok = ok && !s_q.cdb[B_FLAGS][BIT_PTR_CTL]
            && (s_q.cdb[B_PAGE][7:6] == CTL_CUR_CUMUL)
            && ({s_q.cdb[B_PTR_HI], s_q.cdb[B_PTR_LO]} == 16'h0000);
    s_d     = s_q;
    s_d.cv  = 1'b0;
    s_d.rdy = psel && !penable && !s_q.rdy;
    s_d.err = 1'b0;

    if (psel && !penable) begin
      s_d.rd = 32'h0000_0000;
      if (paddr[7:5] == BUF_WIN) begin
        s_d.rd = s_q.buff[paddr[4:2]*4 +: 4];
      end else begin
        case (paddr)
          OFS_CDB0:  s_d.rd = {s_q.cdb[3], s_q.cdb[2], s_q.cdb[1], s_q.cdb[0]};
          OFS_CDB1:  s_d.rd = {s_q.cdb[7], s_q.cdb[6], s_q.cdb[5], s_q.cdb[4]};
          OFS_CDB2:  s_d.rd = {16'h0000, s_q.cdb[9], s_q.cdb[8]};
          OFS_CTRL:  s_d.rd = {30'h0000_0000, s_q.strict, 1'b0};
          OFS_STAT:  s_d.rd = {28'h000_0000, s_q.rej, link.dev_busy, s_q.done, s_q.busy};
          OFS_SENSE: s_d.rd = {12'h000, s_q.asc, s_q.sk, s_q.status};
          OFS_COUNT: s_d.rd = {16'h0000, s_q.cnt};
          default:   s_d.err = 1'b1;
        endcase
      end
    end

    if (wr) begin
      case (paddr)
        OFS_CDB0: s_d.cdb[3:0] = pwdata;
        OFS_CDB1: s_d.cdb[7:4] = pwdata;
        OFS_CDB2: s_d.cdb[9:8] = pwdata[15:0];
        OFS_CTRL: begin
          s_d.strict = pwdata[1];
          // Start is ignored while a command is outstanding
          if (pwdata[0] && !s_q.busy) begin
            s_d.done = 1'b0;
            s_d.rej  = 1'b0;
            s_d.cnt  = 16'h0000;
            if (pwdata[1] && !ok) begin
              s_d.rej  = 1'b1;
              s_d.done = 1'b1;
            end else begin
              s_d.cv   = 1'b1;
              s_d.busy = 1'b1;
              s_d.cdb[B_SUBPAGE] = 8'h00;
            end
          end
        end
        default: s_d.cdb = s_q.cdb;
      endcase
    end

    if (link.din_valid) begin
      if (s_q.cnt < BUF_BYTES) begin
        s_d.buff[s_q.cnt[4:0]] = link.din;
      end
      s_d.cnt = s_q.cnt + 16'h0001;
    end
    if (link.stat_valid) begin
      s_d.busy   = 1'b0;
      s_d.done   = 1'b1;
      s_d.status = link.status;
      s_d.sk     = link.sense_key;
      s_d.asc    = link.asc;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata         = s_q.rd;
  assign pready         = s_q.rdy;
  assign pslverr        = s_q.err;
  assign link.cdb_valid = s_q.cv;
  assign link.cdb       = s_q.cdb;
endmodule

// file: log_link_sva.sv
// Checker on the link between the log sense target and its initiator.
// Assumes one clock pclk and an active-low asynchronous presetn.
`timescale 1ns/1ps
module log_link_sva (
  input wire logic                 pclk,
  input wire logic                 presetn,
  input wire logic                 cdb_valid,
  input wire log_sense_pkg::cdb_t  cdb,
  input wire logic                 dev_busy,
  input wire logic                 din_valid,
  input wire logic [7:0]           din,
  input wire logic                 stat_valid,
  input wire logic [7:0]           status,
  input wire logic [3:0]           sense_key,
  input wire logic [7:0]           asc
);
  import log_sense_pkg::*;
  logic        take;
  logic        clean;
  logic [15:0] alloc;
  // Wrong opcode wins over field checks, so field rules need a good opcode
  assign take  = cdb_valid && !dev_busy && cdb[B_OPC] == OPC_LOG_SENSE;
  assign alloc = {cdb[B_ALLOC_HI], cdb[B_ALLOC_LO]};
  assign clean = take && !cdb[B_FLAGS][BIT_PTR_CTL] && {cdb[B_PTR_HI], cdb[B_PTR_LO]} == 16'h0000;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence bad_field;
    stat_valid && status == STAT_CHECK && sense_key == SK_ILLEGAL && asc == ASC_INV_CDB;
  endsequence
  a_busy_after_take: assert property (cdb_valid && !dev_busy |=> dev_busy)
    else $error("busy did not follow an accepted command");
  a_pointer_bit_reject: assert property (
    take && cdb[B_FLAGS][BIT_PTR_CTL] |-> ##2 bad_field)
    else $error("pointer bit not rejected");
  a_page_ctl_reject: assert property (
    take && cdb[B_PAGE][7:6] != CTL_CUR_CUMUL |-> ##2 bad_field)
    else $error("page control not rejected");
  a_pointer_reject: assert property (
    take && {cdb[B_PTR_HI], cdb[B_PTR_LO]} != 16'h0000 |-> ##2 bad_field)
    else $error("parameter pointer not rejected");
  a_zero_alloc: assert property (take && alloc == 16'h0000 |-> ##1 !din_valid ##1
    stat_valid && !din_valid)
    else $error("zero allocation sent data or late status");
  a_two_byte_cap: assert property (clean && cdb[B_PAGE] == 8'h42 && alloc == 16'h0002
    |-> ##2 din_valid[*2] ##1 (stat_valid && !din_valid && status == STAT_GOOD))
    else $error("allocation cap not kept");
  a_check_no_data: assert property (stat_valid && status == STAT_CHECK |->
    !din_valid && !$past(din_valid))
    else $error("data sent with a check status");
  a_list_header: assert property (clean && cdb[B_PAGE] == 8'h40 && alloc >= 16'h0004
    |-> ##2 din_valid && din == 8'h00 ##1 din == 8'h00 ##1 din == 8'h00 ##1 din == 8'h0F)
    else $error("supported list header wrong");
  a_page_header: assert property (clean && cdb[B_PAGE] == 8'h42 && alloc >= 16'h0004
    |-> ##2 din == 8'h02 ##1 din == 8'h00 ##1 din == 8'h00 ##1 din_valid && din == 8'h10)
    else $error("page header wrong");
  a_subpage_zero: assert property (cdb_valid |-> cdb[B_SUBPAGE] == 8'h00)
    else $error("subpage code not zero");
  c_zero_alloc: cover property (take && alloc == 16'h0000);
  c_rejected: cover property (stat_valid && status == STAT_CHECK);
  c_data_then_status: cover property (din_valid ##1 stat_valid);
endmodule

// file: testbench.sv
// Bench joining the log sense initiator and target over the link.
// Assumes the initiator's APB map and zero-wait answers.
`timescale 1ns/1ps
`define CHK(g, e, m) begin cmp_count++; if ((g) !== (e)) begin errors++; \
  $display("MISMATCH t=%0t %s", $time, m); end end
module testbench;
  import log_sense_pkg::*;
  typedef struct packed {
    logic [7:0]  opc;
    logic [7:0]  flags;
    logic [7:0]  pg;
    logic [15:0] ptr;
    logic [15:0] alloc;
    logic [7:0]  st;
    logic [7:0]  asc;
    logic [15:0] cnt;
  } row_t;
  localparam row_t ROWS [12] = '{
    '{8'h4D, 8'h00, 8'h40, 16'h0000, 16'h0064, 8'h00, 8'h00, 16'h0013},
    '{8'h4D, 8'h00, 8'h42, 16'h0000, 16'h0000, 8'h00, 8'h00, 16'h0000},
    '{8'h4D, 8'h00, 8'h42, 16'h0000, 16'h0002, 8'h00, 8'h00, 16'h0002},
    '{8'h4D, 8'h00, 8'h78, 16'h0000, 16'h0007, 8'h00, 8'h00, 16'h0007},
    '{8'h4D, 8'h00, 8'h42, 16'h0000, 16'h012C, 8'h00, 8'h00, 16'h0014},
    '{8'h4D, 8'h02, 8'h42, 16'h0000, 16'h0010, 8'h02, 8'h24, 16'h0000},
    '{8'h4D, 8'h00, 8'h02, 16'h0000, 16'h0010, 8'h02, 8'h24, 16'h0000},
    '{8'h4D, 8'h00, 8'h82, 16'h0000, 16'h0010, 8'h02, 8'h24, 16'h0000},
    '{8'h4D, 8'h00, 8'hC2, 16'h0000, 16'h0010, 8'h02, 8'h24, 16'h0000},
    '{8'h4D, 8'h00, 8'h41, 16'h0000, 16'h0010, 8'h02, 8'h24, 16'h0000},
    '{8'h4D, 8'h00, 8'h42, 16'h0001, 16'h0010, 8'h02, 8'h24, 16'h0000},
    '{8'h12, 8'h00, 8'h42, 16'h0000, 16'h0010, 8'h02, 8'h20, 16'h0000}};
  logic        pclk      = 1'b0;
  logic        presetn   = 1'b0;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [7:0]  paddr     = 8'h00;
  logic [31:0] pwdata    = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        evt_stb   = 1'b0;
  logic [3:0]  evt_page  = 4'h0;
  logic        evt_param = 1'b0;
  logic        log_reinit = 1'b0;
  logic        save_stb;
  logic        strict    = 1'b0;
  logic        last_err;
  int          errors    = 0;
  int          cmp_count = 0;
  int          save_cnt  = 0;
  int          cyc       = 0;
  logic [31:0] d;

  always #5 pclk = ~pclk;
  log_link_if link (.pclk(pclk), .presetn(presetn));
  log_sense_target log_sense_target_i (.pclk(pclk), .presetn(presetn), .link(link),
    .evt_stb(evt_stb), .evt_page(evt_page), .evt_param(evt_param),
    .log_reinit(log_reinit), .save_stb(save_stb));
  log_sense_initiator log_sense_initiator_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  log_link_sva log_link_sva_i (.pclk(pclk), .presetn(presetn), .cdb_valid(link.cdb_valid),
    .cdb(link.cdb), .dev_busy(link.dev_busy), .din_valid(link.din_valid), .din(link.din),
    .stat_valid(link.stat_valid), .status(link.status), .sense_key(link.sense_key),
    .asc(link.asc));

  task automatic report_and_stop();
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // Hang guard: a full run needs under a thousand cycles
  always @(posedge pclk) begin
    cyc++;
    if (save_stb === 1'b1) save_cnt++;
    if (cyc == 20000) begin
      errors++;
      report_and_stop();
    end
  end

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic run_cmd(input row_t r);
    logic [31:0] q;
    int          n;
    apb(1'b1, OFS_CDB0, {8'h00, r.pg, r.flags, r.opc}, q);
    apb(1'b1, OFS_CDB1, {r.alloc[15:8], r.ptr[7:0], r.ptr[15:8], 8'h00}, q);
    apb(1'b1, OFS_CDB2, {24'h00_0000, r.alloc[7:0]}, q);
    apb(1'b1, OFS_CTRL, {30'h0000_0000, strict, 1'b1}, q);
    q = 32'h0000_0000;
    for (n = 0; n < 100 && q[1] !== 1'b1; n++) apb(1'b0, OFS_STAT, 32'h0000_0000, q);
    `CHK(q[1], 1'b1, "command never completed")
  endtask

  // Byte 4k of the received data sits in bits 7:0 of buffer word k
  task automatic check_buf(input logic [7:0] eb [$]);
    logic [31:0] q;
    foreach (eb[i]) begin
      if (i % 4 == 0) apb(1'b0, 8'h20 + 8'(i), 32'h0000_0000, q);
      `CHK(q[8*(i%4)+:8], eb[i], "log data byte")
    end
  endtask

  task automatic pulse_evt(input logic prm);
    @(posedge pclk);
    evt_stb   <= 1'b1;
    evt_page  <= 4'h1;
    evt_param <= prm;
    @(posedge pclk);
    evt_stb   <= 1'b0;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ROWS[i]) begin
      run_cmd(ROWS[i]);
      apb(1'b0, OFS_SENSE, 32'h0000_0000, d);
      `CHK(d[7:0], ROWS[i].st, "status")
      `CHK(d[11:8], (ROWS[i].st == STAT_CHECK) ? SK_ILLEGAL : SK_NONE, "sense key")
      `CHK(d[19:12], ROWS[i].asc, "additional sense")
      apb(1'b0, OFS_COUNT, 32'h0000_0000, d);
      `CHK(d[15:0], ROWS[i].cnt, "byte count")
    end
    run_cmd(ROWS[0]);
    check_buf('{8'h00, 8'h00, 8'h00, 8'h0F, 8'h00, 8'h02, 8'h03, 8'h05, 8'h06, 8'h0D,
      8'h0E, 8'h0F, 8'h10, 8'h11, 8'h15, 8'h1A, 8'h2F, 8'h30, 8'h38});
    repeat (3) pulse_evt(1'b0);
    pulse_evt(1'b1);
    run_cmd(ROWS[4]);
    check_buf('{8'h02, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00,
      8'h00, 8'h03, 8'h00, 8'h01, 8'h02, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01});
    @(posedge pclk);
    log_reinit <= 1'b1;
    @(posedge pclk);
    log_reinit <= 1'b0;
    run_cmd(ROWS[4]);
    check_buf('{8'h02, 8'h00, 8'h00, 8'h10, 8'h00, 8'h00, 8'h00, 8'h04,
      8'h00, 8'h00, 8'h00, 8'h00});
    `CHK(save_cnt, 0, "save without save bit")
    run_cmd('{8'h4D, 8'h01, 8'h42, 16'h0000, 16'h0010, 8'h00, 8'h00, 16'h0000});
    `CHK(save_cnt, 1, "save bit ignored")
    // Non-zero subpage byte must be cleared by the start itself
    apb(1'b1, OFS_CDB0, 32'h5A42_004D, d);
    apb(1'b1, OFS_CTRL, 32'h0000_0001, d);
    apb(1'b0, OFS_CDB0, 32'h0000_0000, d);
    `CHK(d, 32'h0042_004D, "subpage not forced to zero")
    d = 32'h0000_0000;
    while (d[1] !== 1'b1) apb(1'b0, OFS_STAT, 32'h0000_0000, d);
    strict = 1'b1;
    run_cmd(ROWS[5]);
    strict = 1'b0;
    apb(1'b0, OFS_STAT, 32'h0000_0000, d);
    `CHK(d[3], 1'b1, "strict check did not reject")
    apb(1'b0, 8'h40, 32'h0000_0000, d);
    `CHK(last_err, 1'b1, "unmapped address accepted")
    `CHK(d, 32'h0000_0000, "unmapped read data")
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    `CHK(link.dev_busy, 1'b0, "busy during reset")
    presetn <= 1'b1;
    apb(1'b0, OFS_STAT, 32'h0000_0000, d);
    `CHK(d, 32'h0000_0000, "status after reset")
    report_and_stop();
  end
endmodule
